// ===== rtl/bsc_pkg.sv
// package: register map, field layout, reset values and timing for the speed/advance block
package bsc_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_SPEED_CMD = 8'h04;
  localparam logic [7:0] OFS_ADVANCE   = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_ADV_STAT  = 8'h10;

  // ==========================================================================
  // control and status register field positions
  localparam int POS_SERIAL_SEL  = 0;
  localparam int POS_PIN_TYPE    = 1;
  localparam int POS_EDGE_SEL    = 2;
  localparam int POS_ADV_MODE    = 3;
  localparam int POS_SLEW_LSB    = 4;
  localparam int POS_ATTEN_LSB   = 8;
  localparam int POS_STAT_AMP    = 0;
  localparam int POS_STAT_TARGET = 16;

  // ==========================================================================
  // reset values
  localparam logic [31:0] RST_CTRL      = 32'h0000_0000;
  localparam logic [8:0]  RST_SPEED_CMD = 9'h000;
  localparam logic [6:0]  RST_ADVANCE   = 7'h00;

  // ==========================================================================
  // widths and command range
  localparam int          CMD_W        = 9;
  localparam logic [8:0]  CMD_MAX      = 9'h1ff;
  localparam int          ADV_W        = 21;
  localparam int          PERIOD_W     = 24;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // ==========================================================================
  // timing: advance step and clock
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int ADV_STEP_PS    = 2500000;
  // advance step in half cycles, kept doubled to hold the half cycle exactly
  localparam int ADV_STEP_HCYC  = (2 * ADV_STEP_PS) / CLK_PERIOD_PS;

  // ==========================================================================
  // configuration carried from the register file to the advance timer
  typedef struct packed {
    logic       serial_speed_select;
    logic       pin_input_type;
    logic       zero_cross_edge_select;
    logic       advance_mode_select;
    logic [2:0] closed_loop_slew_rate;
    logic [1:0] feedback_attenuation;
    logic [6:0] advance_setting;
  } bsc_cfg_s;

  typedef enum logic [1:0] {
    SRC_ANALOG,
    SRC_PWM,
    SRC_SERIAL
  } bsc_src_e;

endpackage

// ===== rtl/bsc_adv_timer.sv
// advance timer: setting time, amplitude scaling and early commutation pulse
`timescale 1ns/1ps
module bsc_adv_timer
  import bsc_pkg::*;
(
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // configuration and loop state
  input  wire bsc_cfg_s            cfg,
  input  wire logic [CMD_W-1:0]    amp,
  input  wire logic [CMD_W-1:0]    bemf,
  input  wire logic                zc_trigger,
  // results
  output logic [ADV_W-1:0]         adv_cycles,
  output logic                     commutate
);

  // ==========================================================================
  // setting time in cycles
  logic [10:0]         scaled_mant;
  logic [ADV_W:0]      setting_hcyc;
  logic [ADV_W-1:0]    setting_cyc;
  logic [CMD_W-1:0]    margin;
  logic [ADV_W+8:0]    product;
  logic [ADV_W-1:0]    next_adv;
  logic [PERIOD_W-1:0] count;
  logic [PERIOD_W-1:0] last_period;
  logic [PERIOD_W-1:0] target;

  // mantissa shifted by the shift field, times 2.5 us
  assign scaled_mant  = 11'({7'h00, cfg.advance_setting[3:0]} << cfg.advance_setting[6:4]);
  assign setting_hcyc = (ADV_W+1)'(scaled_mant * ADV_STEP_HCYC);
  // half cycles rounded up so the advance is never short
  assign setting_cyc  = ADV_W'((setting_hcyc + 1'b1) >> 1);

  // mode 1 shrinks the advance as back-emf approaches the drive amplitude
  assign margin  = (amp > bemf) ? (amp - bemf) : '0;
  assign product = (ADV_W+9)'(setting_cyc * margin);

  always_comb begin
    if (!cfg.advance_mode_select) begin
      next_adv = setting_cyc;
    end else if (amp == '0) begin
      next_adv = '0;
    end else begin
      next_adv = ADV_W'(product / amp);
    end
  end

  // registered so the divider does not sit on the compare path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_cycles <= '0;
    end else begin
      adv_cycles <= next_adv;
    end
  end

  // ==========================================================================
  // zero-cross period and early commutation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count       <= '0;
      last_period <= '0;
    end else if (zc_trigger) begin
      last_period <= count;
      count       <= '0;
    end else if (count != '1) begin
      count <= count + 1'b1;
    end
  end

  // fire ahead of the predicted next zero cross; too large an advance fires at once
  assign target = (last_period > PERIOD_W'(adv_cycles)) ? (last_period - PERIOD_W'(adv_cycles)) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      commutate <= 1'b0;
    end else begin
      commutate <= (last_period != '0) && (count == target);
    end
  end

endmodule

// ===== rtl/bsc_top.sv
// speed command selection, slew limit, feedback attenuation and register slave
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module bsc_top
  import bsc_pkg::*;
#(
  parameter int SLEW_BASE_CYC = 125000,
  parameter int PWM_PRESCALE  = 16,
  parameter int CUR_W         = 12
)(
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // axi4-lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // axi4-lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // speed input pin, already converted
  input  wire logic [CMD_W-1:0]    speed_pin_analog,
  input  wire logic                speed_pin_pwm,
  // motor feedback
  input  wire logic                loop_closed,
  input  wire logic                current_valid,
  input  wire logic [CUR_W-1:0]    current_sample,
  input  wire logic                bemf_polarity,
  // drive side
  output logic [CMD_W-1:0]         drive_amplitude,
  output logic [CMD_W-1:0]         bemf_estimate,
  output logic [CUR_W-1:0]         feedback_current,
  output logic                     zero_cross_trigger,
  output logic                     commutate,
  output logic [ADV_W-1:0]         advance_cycles
);

  // ==========================================================================
  // register file
  bsc_cfg_s         cfg;
  logic [CMD_W-1:0] speed_command_value;
  logic [CMD_W-1:0] target_cmd;
  bsc_src_e         src;

  // bus bookkeeping
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       do_write;
  logic [31:0] ctrl_word;
  logic [31:0] next_ctrl;
  logic [31:0] rd_word;
  logic       rd_hit;
  logic       wr_hit;

  assign ctrl_word = {22'h0, cfg.feedback_attenuation, 1'b0, cfg.closed_loop_slew_rate,
                      cfg.advance_mode_select, cfg.zero_cross_edge_select,
                      cfg.pin_input_type, cfg.serial_speed_select};

  // byte-lane merge of a control write
  always_comb begin
    next_ctrl = ctrl_word;
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        next_ctrl[b*8 +: 8] = w_data[b*8 +: 8];
      end
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit   = (aw_addr == OFS_CTRL) || (aw_addr == OFS_SPEED_CMD)
                 || (aw_addr == OFS_ADVANCE);

  // write address and data are taken in either order, then held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_held       <= 1'b0;
      aw_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_held       <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_held       <= 1'b0;
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register updates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.serial_speed_select    <= RST_CTRL[POS_SERIAL_SEL];
      cfg.pin_input_type         <= RST_CTRL[POS_PIN_TYPE];
      cfg.zero_cross_edge_select <= RST_CTRL[POS_EDGE_SEL];
      cfg.advance_mode_select    <= RST_CTRL[POS_ADV_MODE];
      cfg.closed_loop_slew_rate  <= RST_CTRL[POS_SLEW_LSB +: 3];
      cfg.feedback_attenuation   <= RST_CTRL[POS_ATTEN_LSB +: 2];
      cfg.advance_setting        <= RST_ADVANCE;
      speed_command_value        <= RST_SPEED_CMD;
    end else if (do_write) begin
      if (aw_addr == OFS_CTRL) begin
        cfg.serial_speed_select    <= next_ctrl[POS_SERIAL_SEL];
        cfg.pin_input_type         <= next_ctrl[POS_PIN_TYPE];
        cfg.zero_cross_edge_select <= next_ctrl[POS_EDGE_SEL];
        cfg.advance_mode_select    <= next_ctrl[POS_ADV_MODE];
        cfg.closed_loop_slew_rate  <= next_ctrl[POS_SLEW_LSB +: 3];
        cfg.feedback_attenuation   <= next_ctrl[POS_ATTEN_LSB +: 2];
      end
      if (aw_addr == OFS_SPEED_CMD) begin
        if (w_strb[0]) speed_command_value[7:0] <= w_data[7:0];
        if (w_strb[1]) speed_command_value[8]   <= w_data[8];
      end
      if ((aw_addr == OFS_ADVANCE) && w_strb[0]) begin
        cfg.advance_setting <= w_data[6:0];
      end
    end
  end

  // ==========================================================================
  // read channel
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = '0;
    case (s_axi_araddr)
      OFS_CTRL:      rd_word = ctrl_word;
      OFS_SPEED_CMD: rd_word = {23'h0, speed_command_value};
      OFS_ADVANCE:   rd_word = {25'h0, cfg.advance_setting};
      OFS_STATUS: begin
        rd_word[POS_STAT_AMP +: CMD_W]    = drive_amplitude;
        rd_word[POS_STAT_TARGET +: CMD_W] = target_cmd;
      end
      OFS_ADV_STAT:  rd_word = {11'h0, advance_cycles};
      default:       rd_hit  = 1'b0;
    endcase
  end

  // one read at a time; address refused while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ==========================================================================
  // pwm duty decode: high samples over a 511-sample window
  logic [15:0]      pre_cnt;
  logic [CMD_W-1:0] win_cnt;
  logic [CMD_W-1:0] high_cnt;
  logic [CMD_W-1:0] pwm_duty;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt  <= '0;
      win_cnt  <= '0;
      high_cnt <= '0;
      pwm_duty <= '0;
    end else if (pre_cnt == 16'(PWM_PRESCALE - 1)) begin
      pre_cnt <= '0;
      if (win_cnt == CMD_MAX - 1'b1) begin
        win_cnt  <= '0;
        high_cnt <= '0;
        pwm_duty <= high_cnt + CMD_W'(speed_pin_pwm);
      end else begin
        win_cnt  <= win_cnt + 1'b1;
        high_cnt <= high_cnt + CMD_W'(speed_pin_pwm);
      end
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  // ==========================================================================
  // command source; the pin path is not looked at in serial mode
  always_comb begin
    if (cfg.serial_speed_select) begin
      src = SRC_SERIAL;
    end else if (cfg.pin_input_type) begin
      src = SRC_PWM;
    end else begin
      src = SRC_ANALOG;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_cmd <= '0;
    end else begin
      case (src)
        SRC_SERIAL: target_cmd <= speed_command_value;
        SRC_PWM:    target_cmd <= pwm_duty;
        SRC_ANALOG: target_cmd <= speed_pin_analog;
        default:    target_cmd <= '0;
      endcase
    end
  end

  // ==========================================================================
  // slew limiter: one lsb per interval; higher setting = shorter interval
  logic [31:0] slew_cnt;
  logic [31:0] slew_int;

  assign slew_int = 32'(SLEW_BASE_CYC) >> {cfg.closed_loop_slew_rate, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slew_cnt        <= '0;
      drive_amplitude <= '0;
    end else if (slew_cnt + 1'b1 >= slew_int) begin
      slew_cnt <= '0;
      if (drive_amplitude < target_cmd) begin
        drive_amplitude <= drive_amplitude + 1'b1;
      end else if (drive_amplitude > target_cmd) begin
        drive_amplitude <= drive_amplitude - 1'b1;
      end
    end else begin
      slew_cnt <= slew_cnt + 1'b1;
    end
  end
  // 511 is simply the top code of the 9-bit amplitude

  // ==========================================================================
  // current feedback and back-emf estimate in closed loop
  logic [CUR_W-1:0] atten_cur;

  // attenuation trades loop speed for noise immunity
  assign atten_cur = current_sample >> cfg.feedback_attenuation;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feedback_current <= '0;
      bemf_estimate    <= '0;
    end else if (loop_closed && current_valid) begin
      feedback_current <= atten_cur;
      if (CUR_W'(drive_amplitude) > atten_cur) begin
        bemf_estimate <= CMD_W'(CUR_W'(drive_amplitude) - atten_cur);
      end else begin
        bemf_estimate <= '0;
      end
    end
  end

  // ==========================================================================
  // zero-cross trigger from back-emf polarity
  logic pol_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_q              <= 1'b0;
      zero_cross_trigger <= 1'b0;
    end else begin
      pol_q              <= bemf_polarity;
      zero_cross_trigger <= loop_closed && ((bemf_polarity && !pol_q)
                         || (cfg.zero_cross_edge_select && !bemf_polarity && pol_q));
    end
  end

  // ==========================================================================
  // advance timer
  bsc_adv_timer u_adv (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .cfg        (cfg),
    .amp        (drive_amplitude),
    .bemf       (bemf_estimate),
    .zc_trigger (zero_cross_trigger),
    .adv_cycles (advance_cycles),
    .commutate  (commutate)
  );

endmodule

// ===== bench/bsc_chk.sv
// checker: bus answers, slew and pulse properties of the speed block
`timescale 1ns/1ps
module bsc_chk
  import bsc_pkg::*;
(
  // clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // register bus
  input wire logic [7:0]       s_axi_awaddr,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  // drive side
  input wire logic             loop_closed,
  input wire logic             bemf_polarity,
  input wire logic [CMD_W-1:0] drive_amplitude,
  input wire logic             zero_cross_trigger,
  input wire logic             commutate
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // bus answers; writes assume address and data offered together
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  a_wr_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_awaddr > 8'h10 |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
    else $error("bad unmapped write");
  // ==========================================================================
  // drive side: one lsb per step, single-cycle pulses
  a_amp_slew: assert property (drive_amplitude == $past(drive_amplitude)
    || drive_amplitude == $past(drive_amplitude) + 9'h001
    || drive_amplitude == $past(drive_amplitude) - 9'h001) else $error("amplitude jumped");
  a_zc_rise: assert property (loop_closed && $rose(bemf_polarity) |=>
    zero_cross_trigger) else $error("rising zero cross missed");
  a_zc_cause: assert property (zero_cross_trigger |->
    $past(bemf_polarity) != $past(bemf_polarity, 2)) else $error("trigger without cross");
  a_zc_pulse: assert property (zero_cross_trigger |=> !zero_cross_trigger)
    else $error("trigger too long");
  a_comm_pulse: assert property (commutate |=> !commutate)
    else $error("commutate too long");
endmodule

bind bsc_top bsc_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .loop_closed, .bemf_polarity,
  .drive_amplitude, .zero_cross_trigger, .commutate);

// ===== bench/bsc_motor.sv
// motor model: current samples and back-emf sign seen by the closed loop
`timescale 1ns/1ps
module bsc_motor #(
  parameter int HALF = 50
)(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // current level chosen by the bench
  input  wire logic [11:0] cur_level,
  // sensed motor quantities
  output logic             current_valid,
  output logic [11:0]      current_sample,
  output logic             bemf_polarity
);
  int cnt;
  // ==========================================================================
  // sample when the low 3 bits of the 100-cycle count are 7; bus carries inverted junk between samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      current_valid <= 1'b0;
      current_sample <= 12'h000;
      bemf_polarity <= 1'b0;
    end else begin
      cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
      current_valid <= (cnt[2:0] == 3'h7);
      current_sample <= (cnt[2:0] == 3'h7) ? cur_level : ~cur_level;
      if (cnt == HALF - 1 || cnt == 2 * HALF - 1) begin
        bemf_polarity <= ~bemf_polarity;
      end
    end
  end
endmodule

// ===== bench/testbench.sv
// testbench: bus tasks, motor model and queued checks of the speed block
`timescale 1ns/1ps
module testbench
  import bsc_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, speed_pin_pwm;
  logic        loop_closed, current_valid, bemf_polarity, zero_cross_trigger, commutate, rnd_en;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [8:0]  speed_pin_analog, drive_amplitude, bemf_estimate;
  logic [11:0] current_sample, feedback_current, cur_level;
  logic [20:0] advance_cycles;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  logic [6:0]  av;
  int          failures, num_checks, cyc;
  integer      seed = 32'h8e45e61c;

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // short slew base and pwm window keep the run brief
  bsc_top #(.SLEW_BASE_CYC(16), .PWM_PRESCALE(1)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .speed_pin_analog, .speed_pin_pwm, .loop_closed, .current_valid,
    .current_sample, .bemf_polarity, .drive_amplitude, .bemf_estimate, .feedback_current,
    .zero_cross_trigger, .commutate, .advance_cycles);
  bsc_motor u_motor (.aclk, .aresetn, .cur_level, .current_valid,
    .current_sample, .bemf_polarity);

  // ==========================================================================
  // verdict and checks
  task automatic final_report;
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] lo, hi, got);
    num_checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      failures++;
      $display("mismatch %s exp %0d..%0d got %0d", n, lo, hi, got);
    end
  endtask
  task automatic cmp_rd(input logic [65:0] e);
    num_checks++;
    if (((s_axi_rdata & e[65:34]) !== e[33:2]) || (s_axi_rresp !== e[1:0])) begin
      failures++;
      $display("mismatch rdata exp %0h/%0h got %0h/%0h", e[33:2], e[1:0], s_axi_rdata,
        s_axi_rresp);
    end
  endtask
  task automatic cmp_b(input logic [1:0] e);
    num_checks++;
    if (s_axi_bresp !== e) begin
      failures++;
      $display("mismatch bresp exp %0h got %0h", e, s_axi_bresp);
    end
  endtask
  // ready is tied high, so every valid edge is a handshake
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && s_axi_rvalid === 1'b1) cmp_rd(rq.pop_front());
    if (aresetn === 1'b1 && s_axi_bvalid === 1'b1) cmp_b(bq.pop_front());
    cyc++;
    if (cyc == 30000) begin
      failures++;
      final_report;
    end
  end

  // ==========================================================================
  // bus master; noted expectation goes in before the request
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                    input logic [3:0] s = 4'hf);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid & ~s_axi_awready) | (s_axi_wvalid & ~s_axi_wready));
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                    input logic [31:0] m = 32'hffff_ffff);
    rq.push_back({m, d, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
  endtask

  // ==========================================================================
  // scenario helpers
  function automatic logic [31:0] adv_exp(input logic [6:0] v);
    logic [31:0] m;
    m = 32'(v[3:0]) << v[6:4];
    return (m * 625 + 1) / 2;
  endfunction
  task automatic ramp(input logic [31:0] ctl, input logic [8:0] tgt, input int iv);
    logic [31:0] n, d;
    wr(OFS_CTRL, ctl, RESP_OKAY);
    wr(OFS_SPEED_CMD, {23'h0, tgt}, RESP_OKAY);
    d = (tgt > drive_amplitude) ? tgt - drive_amplitude : drive_amplitude - tgt;
    n = 0;
    while (drive_amplitude !== tgt && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    chk("ramp_cycles", d * iv - iv - 2, d * iv + iv + 2, n);
  endtask
  task automatic zc(input logic [31:0] ctl, input logic both);
    int nz, ne, nc;
    logic p;
    wr(OFS_CTRL, ctl, RESP_OKAY);
    repeat (4) @(posedge aclk);
    nz = 0;
    nc = 0;
    ne = 0;
    p = bemf_polarity;
    repeat (1000) begin
      @(posedge aclk);
      if (zero_cross_trigger === 1'b1) nz++;
      if (commutate === 1'b1) nc++;
      if (bemf_polarity !== p && (both || bemf_polarity === 1'b1)) ne++;
      p = bemf_polarity;
    end
    chk("zc_count", ne - 1, ne + 1, nz);
    chk("commutate_count", nz - 1, nz + 1, nc);
  endtask
  // pin source: random while serial control must ignore it
  always @(posedge aclk) begin
    speed_pin_analog <= rnd_en ? 9'($random(seed)) : 9'h0a5;
    speed_pin_pwm <= rnd_en ? 1'($random(seed)) : 1'b1;
  end

  // ==========================================================================
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rnd_en} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, cur_level} = '0;
    loop_closed = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    loop_closed <= 1'b1;
    rd(OFS_CTRL, RST_CTRL, RESP_OKAY);
    rd(OFS_SPEED_CMD, {23'h0, RST_SPEED_CMD}, RESP_OKAY);
    rd(OFS_ADVANCE, {25'h0, RST_ADVANCE}, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'hffff_ffff, RESP_SLVERR);
    wr(OFS_CTRL, 32'h37f, RESP_OKAY);
    rd(OFS_CTRL, 32'h37f, RESP_OKAY);
    wr(OFS_CTRL, 32'h0, RESP_OKAY, 4'h2);
    rd(OFS_CTRL, 32'h07f, RESP_OKAY);
    wr(OFS_CTRL, 32'h012, RESP_OKAY);
    repeat (1100) @(posedge aclk);
    rd(OFS_STATUS, 32'h01ff_0000, RESP_OKAY, 32'h01ff_0000);
    wr(OFS_CTRL, 32'h010, RESP_OKAY);
    repeat (4) @(posedge aclk);
    rd(OFS_STATUS, 32'h00a5_0000, RESP_OKAY, 32'h01ff_0000);
    rnd_en <= 1'b1;
    ramp(32'h011, 9'h1ff, 4);
    rd(OFS_STATUS, 32'h01ff_01ff, RESP_OKAY);
    ramp(32'h001, 9'h100, 16);
    rd(OFS_STATUS, 32'h0100_0100, RESP_OKAY);
    // advance swept over fixed and random settings, each checked against its expected cycle count
    for (int i = 0; i < 5; i++) begin
      av = (i == 4) ? 7'($random(seed)) : (i == 0) ? 7'h7f : (i == 1) ? 7'h01 : 7'(i + 24);
      wr(OFS_ADVANCE, {25'h0, av}, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk("advance_cycles", adv_exp(av), adv_exp(av), {11'h0, advance_cycles});
      rd(OFS_ADV_STAT, adv_exp(av), RESP_OKAY);
    end
    // mode 1 at amplitude 256: zero current leaves no advance
    wr(OFS_ADVANCE, 32'h7f, RESP_OKAY);
    wr(OFS_CTRL, 32'h009, RESP_OKAY);
    repeat (30) @(posedge aclk);
    rd(OFS_ADV_STAT, 32'h0, RESP_OKAY);
    cur_level <= 12'h080;
    for (int a = 0; a < 4; a++) begin
      wr(OFS_CTRL, 32'h009 | (a << 8), RESP_OKAY);
      repeat (30) @(posedge aclk);
      chk("feedback", 128 >> a, 128 >> a, {20'h0, feedback_current});
      chk("bemf", 256 - (128 >> a), 256 - (128 >> a), {23'h0, bemf_estimate});
      rd(OFS_ADV_STAT, 32'd300000 >> a, RESP_OKAY);
    end
    zc(32'h001, 1'b0);
    zc(32'h005, 1'b1);
    repeat (4) @(posedge aclk);
    final_report;
  end
endmodule
